// >>> tb/cct_flash_model.sv
`timescale 1ns/100ps
// CPU and flash side: tallies executed cycles
module cct_flash_model (
  // Clock and throttle outputs
  input wire logic core_clk,
  input wire logic cpu_cycle_en,
  input wire logic program_flash_fetch_en,
  input wire logic [cct_pkg::PHASES-1:0] periph_phase,
  // Tallies
  output int starts,
  output int misses
);
  logic prev_fetch = 1'b1;
  initial begin
    starts = 0;
    misses = 0;
  end
  // A cycle starts at phase 0; it needs a fetch the clock before
  always @(posedge core_clk) begin
    if (periph_phase[0] && cpu_cycle_en === 1'b1) begin
      starts <= starts + 1;
      if (prev_fetch !== 1'b1) misses <= misses + 1;
    end
    prev_fetch <= program_flash_fetch_en;
  end
endmodule

// >>> tb/cct_throttle_tb.sv
`timescale 1ns/100ps
module cct_throttle_tb;
  logic core_clk = 1'b0, rst = 1'b1, cycle_skip_enable = 1'b0;
  logic [cct_pkg::RATIO_W-1:0] skip_ratio = 3'h0;
  logic cpu_cycle_en, program_flash_fetch_en, periph_clk_en, bandgap_en, osc_en;
  logic [cct_pkg::PHASES-1:0] periph_phase;
  int starts, misses, got, n_fail = 0, tests_run = 0;
  always #5 core_clk = ~core_clk;
  cct_throttle dut_u (.core_clk(core_clk), .rst(rst), .cycle_skip_enable(cycle_skip_enable),
    .skip_ratio(skip_ratio), .cpu_cycle_en(cpu_cycle_en),
    .program_flash_fetch_en(program_flash_fetch_en), .periph_phase(periph_phase),
    .periph_clk_en(periph_clk_en), .bandgap_en(bandgap_en), .osc_en(osc_en));
  cct_flash_model fm_u (.core_clk(core_clk), .cpu_cycle_en(cpu_cycle_en),
    .program_flash_fetch_en(program_flash_fetch_en), .periph_phase(periph_phase),
    .starts(starts), .misses(misses));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Settle 64 clocks so a pending idle run ends, then watch n clocks
  task automatic run(input logic en, input logic [2:0] r, input int n);
    int s0;
    logic [3:0] ph;
    @(posedge core_clk) #1;
    cycle_skip_enable = en;
    skip_ratio = r;
    repeat (64) @(posedge core_clk);
    #1 s0 = starts;
    ph = periph_phase;
    repeat (n) begin
      @(posedge core_clk) #1;
      chk({periph_clk_en, bandgap_en, osc_en}, 3'h7);
      chk(periph_phase, {ph[2:0], ph[3]});
      ph = periph_phase;
    end
    got = starts - s0;
    $display("setting en=%0b ratio=%0h done", en, r);
  endtask
  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge core_clk);
    #1 rst = 1'b0;
    run(1'b0, 3'h0, 64);
    chk(got, 32'h10);
    run(1'b1, cct_pkg::RATIO_1_4, 64);
    chk(got, 32'h4);
    // Period is 8 clocks times 2^r, so 128 clocks hold 16>>r starts
    for (int r = 0; r < 3; r++) begin
      run(1'b1, 3'(r), 128);
      chk(got, 32'h10 >> r);
    end
    chk(misses, 32'h0);
    wrap_up();
  end
endmodule

// >>> verilog/cct_pkg.sv
package cct_pkg;
  // Ratio field width and documented codes
  localparam int RATIO_W = 3;
  localparam logic [2:0] RATIO_1_4 = 3'h1;
  // Four clock phases make one instruction cycle
  localparam int PHASES = 4;
  localparam logic [1:0] PHASE_LAST = 2'h3;
  localparam logic [1:0] PHASE_FIRST = 2'h0;
  // Skip counter width covers the largest ratio, 1:256
  localparam int SKIP_W = 8;
  localparam logic [7:0] SKIP_ZERO = 8'h00;
  localparam logic [7:0] SKIP_ONE = 8'h01;
endpackage

// >>> verilog/cct_throttle.sv
`timescale 1ns/100ps
// What this block does
// R01: Bandgap and oscillator enables stay on while throttling; only CPU and flash are gated.
// R02: With the cycle-skip enable set, the CPU runs one instruction cycle in every N, N from the ratio field.
// R03: Ratio code 001 gives 1:4, one active cycle then three idle cycles.
// R04: Peripherals keep their clock enable on every system clock during skipped cycles.
// R05: Flash prefetch for the next active cycle runs as in normal operation.
// R06: Four-phase peripheral clocks keep running without a break while throttled.
// R07: With the enable clear, every instruction cycle executes.
module cct_throttle (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Configuration, from logic on the same clock
  input wire logic cycle_skip_enable,
  input wire logic [cct_pkg::RATIO_W-1:0] skip_ratio,
  // CPU and flash side
  output logic cpu_cycle_en,
  output logic program_flash_fetch_en,
  // Peripheral and analog side
  output logic [cct_pkg::PHASES-1:0] periph_phase,
  output logic periph_clk_en,
  output logic bandgap_en,
  output logic osc_en
);

  typedef struct packed {
    logic [1:0] phase;
    logic [cct_pkg::SKIP_W-1:0] skip_cnt;
    logic cpu_en;
    logic fetch_en;
    logic [cct_pkg::PHASES-1:0] ph_out;
    logic per_en;
    logic bg_en;
    logic os_en;
  } cct_state_t;

  cct_state_t st, next_st;

  // Idle cycles after each active one: 2^(ratio+1)-1, so 001 gives three
  function automatic logic [cct_pkg::SKIP_W-1:0] idle_count(input logic [2:0] r);
    logic [cct_pkg::SKIP_W:0] n;
    // Four-bit shift amount, so code 111 reaches 1:256 instead of wrapping to zero
    n = 9'(1) << (4'(r) + 4'h1);
    return cct_pkg::SKIP_W'(n - 9'(1));
  endfunction

  // Next-state logic; the phase counter never stops, whatever the CPU does
  always_comb begin
    next_st = st;
    next_st.phase = st.phase + 2'h1;                       // R06
    next_st.ph_out = cct_pkg::PHASES'(1) << next_st.phase; // R06
    next_st.per_en = 1'b1;                                 // R04
    next_st.bg_en = 1'b1;                                  // R01
    next_st.os_en = 1'b1;                                  // R01
    if (st.phase == cct_pkg::PHASE_LAST) begin
      // Decide the coming instruction cycle at the cycle boundary only,
      // so a ratio change never splits an instruction cycle
      if (!cycle_skip_enable) begin
        next_st.skip_cnt = cct_pkg::SKIP_ZERO;
        next_st.cpu_en = 1'b1;                             // R07
      end else if (st.skip_cnt == cct_pkg::SKIP_ZERO) begin
        next_st.skip_cnt = idle_count(skip_ratio);         // R02 R03
        next_st.cpu_en = 1'b1;
      end else begin
        next_st.skip_cnt = st.skip_cnt - cct_pkg::SKIP_ONE;
        next_st.cpu_en = 1'b0;                             // R02
      end
    end
    // Fetch runs in the cycle before an active one, as in normal mode
    next_st.fetch_en = !cycle_skip_enable ||
                       (next_st.skip_cnt == cct_pkg::SKIP_ONE) ||
                       (next_st.skip_cnt == cct_pkg::SKIP_ZERO); // R05
  end

  // State register; reset starts unthrottled at the last phase, so the first edge after reset enters phase zero
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st <= '0;
      st.phase <= cct_pkg::PHASE_LAST;
      st.cpu_en <= 1'b1;
      st.fetch_en <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign cpu_cycle_en = st.cpu_en;
  assign program_flash_fetch_en = st.fetch_en;
  assign periph_phase = st.ph_out;
  assign periph_clk_en = st.per_en;
  assign bandgap_en = st.bg_en;
  assign osc_en = st.os_en;

  // Checks; each sits out reset so the reset values never trip it

  // Analog and peripheral enables never drop once out of reset
  a_analog_on: assert property (@(posedge core_clk) disable iff (rst)
    $past(!rst) |-> bandgap_en && osc_en) else $error("analog off"); // R01
  a_periph_on: assert property (@(posedge core_clk) disable iff (rst)
    $past(!rst) |-> periph_clk_en) else $error("periph gated"); // R04

  // Enables settle on the first edge after reset and then never move
  property p_analog_steady;
    @(posedge core_clk) disable iff (rst)
    $past(!rst, 2) |-> $stable(bandgap_en) && $stable(osc_en);
  endproperty
  a_analog_steady: assert property (p_analog_steady) else $error("analog toggled"); // R01

  // Peripheral clock enable has no gap during skipped cycles
  property p_periph_steady;
    @(posedge core_clk) disable iff (rst)
    $past(!rst, 2) |-> $stable(periph_clk_en);
  endproperty
  a_periph_steady: assert property (p_periph_steady) else $error("periph toggled"); // R04

  // Phase walk: each phase follows the one before, whatever the CPU does
  a_phase_walk: assert property (@(posedge core_clk) disable iff (rst)
    $past(!rst) && periph_phase[0] |=> periph_phase[1] ##1 periph_phase[2] ##1 periph_phase[3]
    ) else $error("phase broke"); // R06

  // Exactly one phase is high at a time
  property p_phase_hot;
    @(posedge core_clk) disable iff (rst)
    $past(!rst) |-> $onehot(periph_phase);
  endproperty
  a_phase_hot: assert property (p_phase_hot) else $error("phase not one-hot"); // R06

  // The last phase wraps to the first without a break
  property p_phase_wrap;
    @(posedge core_clk) disable iff (rst)
    $past(!rst) && periph_phase[3] |=> periph_phase[0];
  endproperty
  a_phase_wrap: assert property (p_phase_wrap) else $error("phase wrap lost"); // R06

  // A 1:4 active cycle that ends with the ratio still 001
  sequence s_active_1_4;
    cycle_skip_enable && skip_ratio == cct_pkg::RATIO_1_4 && $rose(cpu_cycle_en)
    ##3 cycle_skip_enable && skip_ratio == cct_pkg::RATIO_1_4;
  endsequence

  // Three idle instruction cycles, split in two runs to keep the unroll short
  sequence s_idle3;
    !cpu_cycle_en [*8] ##1 !cpu_cycle_en [*4];
  endsequence

  a_ratio_4: assert property (@(posedge core_clk) disable iff (rst)
    s_active_1_4 |=> s_idle3) else $error("1:4 idle wrong"); // R03

  // Start of an active instruction cycle
  sequence s_cycle_rise;
    $rose(cpu_cycle_en);
  endsequence

  // An active cycle begins on the first phase
  property p_start_phase;
    @(posedge core_clk) disable iff (rst)
    s_cycle_rise |-> periph_phase[0];
  endproperty
  a_start_phase: assert property (p_start_phase) else $error("start off phase"); // R02

  // The internal phase agrees at the start of an active cycle
  property p_rise_first;
    @(posedge core_clk) disable iff (rst)
    s_cycle_rise |-> st.phase == cct_pkg::PHASE_FIRST;
  endproperty
  a_rise_first: assert property (p_rise_first) else $error("start off boundary"); // R02

  // An active cycle holds for all four phases
  property p_active_len;
    @(posedge core_clk) disable iff (rst)
    s_cycle_rise |-> cpu_cycle_en [*4];
  endproperty
  a_active_len: assert property (p_active_len) else $error("active cut short"); // R02

  // Unthrottled: every cycle runs
  a_skip_off: assert property (@(posedge core_clk) disable iff (rst)
    !cycle_skip_enable && st.phase == cct_pkg::PHASE_LAST |=> cpu_cycle_en
    ) else $error("cycle skipped"); // R07

  // Unthrottled: a decided cycle runs for all four clocks
  property p_off_full;
    @(posedge core_clk) disable iff (rst)
    !cycle_skip_enable && st.phase == cct_pkg::PHASE_LAST |=> cpu_cycle_en [*4];
  endproperty
  a_off_full: assert property (p_off_full) else $error("unthrottled gap"); // R07

  // Unthrottled: no idle count is left to replay when throttling resumes
  property p_skip_clear;
    @(posedge core_clk) disable iff (rst)
    !cycle_skip_enable && st.phase == cct_pkg::PHASE_LAST |=> st.skip_cnt == cct_pkg::SKIP_ZERO;
  endproperty
  a_skip_clear: assert property (p_skip_clear) else $error("idle count left"); // R07

  // Throttled: an idle count above zero skips the coming cycle
  a_skip_idle: assert property (@(posedge core_clk) disable iff (rst)
    cycle_skip_enable && st.phase == cct_pkg::PHASE_LAST && st.skip_cnt != cct_pkg::SKIP_ZERO
    |=> !cpu_cycle_en) else $error("ran in idle"); // R02

  // Throttled: the idle count drops by one per instruction cycle
  property p_count_down;
    @(posedge core_clk) disable iff (rst)
    cycle_skip_enable && st.phase == cct_pkg::PHASE_LAST && st.skip_cnt != cct_pkg::SKIP_ZERO
    |=> st.skip_cnt == $past(st.skip_cnt) - cct_pkg::SKIP_ONE;
  endproperty
  a_count_down: assert property (p_count_down) else $error("idle count step"); // R02

  // The CPU enable moves only at an instruction-cycle boundary
  a_cpu_hold: assert property (@(posedge core_clk) disable iff (rst)
    st.phase != cct_pkg::PHASE_LAST |=> $stable(cpu_cycle_en)) else $error("mid change"); // R02

  // Unthrottled: fetch never pauses
  a_fetch_pre: assert property (@(posedge core_clk) disable iff (rst)
    !cycle_skip_enable |=> program_flash_fetch_en) else $error("no fetch"); // R05

  // Throttled: fetch is on at the first clock of the idle cycle before an active one
  property p_fetch_lead;
    @(posedge core_clk) disable iff (rst)
    cycle_skip_enable && st.phase == cct_pkg::PHASE_LAST && st.skip_cnt == cct_pkg::SKIP_ONE
    |=> program_flash_fetch_en;
  endproperty
  a_fetch_lead: assert property (p_fetch_lead) else $error("no fetch lead"); // R05

endmodule
